// ---- logic/ddc_curve_eval.sv ----
// Dependent delay curve evaluator with AHB-Lite register slave
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`default_nettype none
// Function
// R1 - Reciprocal earth curve: k/(0.339-0.236/ratio)
// R2 - Logarithmic earth curve: 5.8-1.35 ln(ratio/k)
// R3 - Integrate delay fraction so varying values work
// R4 - Parameter modes use constants A to E
// R5 - Parameter modes keep standard equation shapes
// R6 - Flag error when constants prevent evaluation
// R7 - Minimum definite delay from twenty times start
// R8 - Software fills table from first line
// R9 - Software orders points by rising current
// R10 - Software pads unused points with 1.00/0s
// R11 - Flag error when table interpolation fails
// R12 - New points used only after restart
// R13 - Sixteen points, linear interpolation between neighbours
// R14 - IEC form k*A/(ratio^B-1)
// R15 - IEEE form k*(A/(ratio^C-1)+B)
// R16 - Release time constant for every curve
module ddc_curve_eval
    import ddc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC_DEF
) (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic                    hresp,
    output logic [31:0]             hrdata,
    input  wire logic signed [31:0] meas_value,
    output logic                    trip,
    output logic                    set_err,
    output logic [31:0]             delay_s
);
    if (TICK_CYCLES < 2) begin : g_chk
        $error("TICK_CYCLES must be at least 2");
    end

    // ************************************************************
    // Fixed point helpers
    // ************************************************************
    function automatic logic signed [31:0] qmul(input logic signed [31:0] a,
                                                input logic signed [31:0] b);
        logic signed [63:0] p;
        p = 64'(a) * 64'(b);
        return p[47:16];
    endfunction

    function automatic logic signed [31:0] qdiv(input logic signed [31:0] a,
                                                input logic signed [31:0] b);
        logic signed [63:0] n;
        n = 64'(a) <<< FRAC;
        return (b == 0) ? Q_MAX : 32'(n / 64'(b));
    endfunction

    // Piecewise linear log2, good to a few percent
    function automatic logic signed [31:0] qlog2(input logic [31:0] x);
        int         p;
        logic [31:0] n;
        p = 0;
        for (int i = 0; i < 32; i++) begin
            if (x[i]) begin
                p = i;
            end
        end
        n = x << (31 - p);
        return {16'(p - FRAC), n[30:15]};
    endfunction

    function automatic logic signed [31:0] qexp2(input logic signed [31:0] y);
        logic signed [15:0] e;
        logic [47:0]        m;
        e = y[31:16];
        m = {31'd0, 1'b1, y[15:0]};
        if (e >= 16'sd14) begin
            return Q_MAX;
        end
        if (e < 0) begin
            return 32'(m >> 16'(-e));
        end
        return 32'(m << e);
    endfunction

    // ************************************************************
    // Bus slave
    // ************************************************************
    ddc_aph_type                     aph_reg;
    ddc_aph_type                     aph_next;
    logic [31:0]                     rdata_reg;
    logic [31:0]                     rd_mux;
    logic                            wr_now;
    logic                            restart;
    logic                            wr_tbl;
    logic                            wr_par;
    logic [7:0]                      tbl_off;
    logic [7:0]                      par_off;
    logic [7:0]                      rd_tbl_off;
    logic [7:0]                      rd_par_off;
    logic [5:0]                      ctrl_reg;
    logic signed [31:0]              k_reg;
    logic signed [31:0]              start_reg;
    logic signed [31:0]              mindt_reg;
    logic [31:0]                     rls_reg;
    logic [NPAR-1:0][31:0]           par_reg;
    ddc_point_type [NPT-1:0]         stg_pt;
    ddc_point_type [NPT-1:0]         act_pt;

    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = rdata_reg;
    assign aph_next   = '{vld: hsel && htrans[1] && hready, wr: hwrite, addr: haddr[7:0]};
    assign wr_now     = aph_reg.vld && aph_reg.wr;
    assign tbl_off    = aph_reg.addr - OFS_TBL;
    assign par_off    = aph_reg.addr - OFS_PAR;
    assign wr_tbl     = wr_now && aph_reg.addr >= OFS_TBL && aph_reg.addr < OFS_TBL_END;
    assign wr_par     = wr_now && aph_reg.addr >= OFS_PAR && aph_reg.addr < OFS_PAR_END;
    assign restart    = wr_now && aph_reg.addr == OFS_CTRL && hwdata[CTRL_RST_BIT];
    assign rd_tbl_off = haddr[7:0] - OFS_TBL;
    assign rd_par_off = haddr[7:0] - OFS_PAR;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph_reg   <= '0;
            rdata_reg <= '0;
        end else begin
            aph_reg   <= aph_next;
            if (aph_next.vld && !hwrite) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg  <= M_IEC;
            k_reg     <= MULT_RST;
            start_reg <= START_RST;
            mindt_reg <= MINDT_RST;
            rls_reg   <= RLS_RST;
            par_reg   <= {96'd0, PB_RST, PA_RST};
            stg_pt    <= {NPT{PT_UNUSED}};
        end else if (wr_now) begin
            unique case (aph_reg.addr)
                OFS_CTRL:  ctrl_reg  <= hwdata[5:0];
                OFS_MULT:  k_reg     <= hwdata;
                OFS_START: start_reg <= hwdata;
                OFS_MINDT: mindt_reg <= hwdata;
                OFS_RLS:   rls_reg   <= hwdata;
                default: begin
                    if (wr_par) begin
                        par_reg[par_off[4:2]] <= hwdata;
                    end
                    if (wr_tbl && tbl_off[2]) begin
                        stg_pt[tbl_off[6:3]].dly <= hwdata;
                    end else if (wr_tbl) begin
                        stg_pt[tbl_off[6:3]].cur <= hwdata;
                    end
                end
            endcase
        end
    end

    // Staged points only go live on restart; mid-fault the live table shifts only on a restart write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_pt <= {NPT{PT_UNUSED}};
        end else if (restart) begin
            act_pt <= stg_pt; // R12
        end
    end

    // ************************************************************
    // Curve equations
    // ************************************************************
    ddc_mode_type       mode;
    logic signed [31:0] r_q, lr, pw_b, pw_c, x1, x2, x3, rec_den;
    logic signed [31:0] t_iec, t_ieee, t_ie2, t_rec, t_lg, t_tb, t_raw, t_next;
    logic signed [31:0] par_a, par_b, par_c, par_d, par_e;
    logic               pickup;
    logic               cond_err;
    logic               tbl_err;
    logic               err_next;

    assign mode   = ddc_mode_type'(ctrl_reg);
    assign par_a  = par_reg[0];
    assign par_b  = par_reg[1];
    assign par_c  = par_reg[2];
    assign par_d  = par_reg[3];
    assign par_e  = par_reg[4];
    assign r_q    = qdiv(meas_value, start_reg);
    assign pickup = r_q > Q_ONE;
    assign lr     = qlog2(r_q);
    assign pw_b   = qexp2(qmul(lr, par_b));
    assign pw_c   = qexp2(qmul(lr, par_c));
    assign t_iec  = qmul(k_reg, qdiv(par_a, pw_b - Q_ONE)); // R14 R4 R5
    assign t_ieee = qmul(k_reg, qdiv(par_a, pw_c - Q_ONE) + par_b); // R15 R4 R5
    assign x1     = r_q - par_c;
    assign x2     = qmul(x1, x1);
    assign x3     = qmul(x2, x1);
    assign t_ie2  = qmul(k_reg, par_a + qdiv(par_b, x1) + qdiv(par_d, x2) + qdiv(par_e, x3));
    assign rec_den = REC_A - qdiv(REC_B, r_q);
    assign t_rec   = qdiv(k_reg, rec_den); // R1
    assign t_lg   = LG_A - qmul(LG_B, qmul(lr - qlog2(k_reg), LN2)); // R2

    // ************************************************************
    // Programmed table
    // ************************************************************
    logic [NPT-1:0]        used, seg, bad;
    ddc_point_type [NPT:0] lo_acc, hi_acc, top_acc;
    ddc_point_type         lo, hi, last;

    assign lo_acc[0]  = '0;
    assign hi_acc[0]  = '0;
    assign top_acc[0] = PT_UNUSED;
    for (genvar i = 0; i < NPT; i++) begin : g_pt
        localparam int J = (i < NPT - 1) ? i + 1 : i;
        assign used[i] = (i == 0) || (act_pt[i] != PT_UNUSED);
        assign seg[i]  = (i < NPT - 1) && used[J]
                         && r_q >= act_pt[i].cur && r_q < act_pt[J].cur; // R13
        assign bad[i]  = (i < NPT - 1) && used[J]
                         && (!used[i] || act_pt[J].cur <= act_pt[i].cur); // R11
        assign lo_acc[i+1]  = lo_acc[i] | (seg[i] ? act_pt[i] : '0);
        assign hi_acc[i+1]  = hi_acc[i] | (seg[i] ? act_pt[J] : '0);
        assign top_acc[i+1] = used[i] ? act_pt[i] : top_acc[i];
    end
    assign lo      = lo_acc[NPT];
    assign hi      = hi_acc[NPT];
    assign last    = top_acc[NPT];
    assign tbl_err = (|bad) || !used[1]; // R11
    // Beyond the last point its delay holds as a definite floor
    assign t_tb    = (|seg) ? lo.dly + qdiv(qmul(hi.dly - lo.dly, r_q - lo.cur),
                                            hi.cur - lo.cur) // R13
                   : (r_q >= last.cur) ? last.dly : Q_MAX;

    // ************************************************************
    // Mode selection, errors and floor
    // ************************************************************
    always_comb begin
        t_raw    = Q_MAX;
        cond_err = 1'b0;
        unique case (mode)
            M_IEC: begin
                t_raw    = t_iec;
                cond_err = pw_b <= Q_ONE || t_iec < 0; // R6
            end
            M_IEEE: begin
                t_raw    = t_ieee;
                cond_err = pw_c <= Q_ONE || t_ieee < 0; // R6
            end
            M_IEEE2: begin
                t_raw    = t_ie2;
                cond_err = x1 <= 0 || x3 == 0 || t_ie2 < 0; // R6
            end
            M_RECIP: begin
                t_raw    = t_rec;
                cond_err = rec_den <= 0; // R1
            end
            M_LOG:   t_raw = t_lg;
            M_TABLE: t_raw = t_tb;
            default: cond_err = 1'b1;
        endcase
    end

    assign err_next = (pickup && cond_err) || (mode == M_TABLE && tbl_err);
    assign t_next   = !pickup ? Q_MAX
                    : (r_q >= Q_TWENTY || t_raw < mindt_reg) ? mindt_reg : t_raw; // R7

    // ************************************************************
    // Real time integration and release
    // ************************************************************
    logic [31:0] tick_cnt_reg;
    logic [31:0] acc_reg, acc_next, rel_reg, rel_next, inc;
    logic [32:0] acc_sum;
    logic        tick, run, rel_done, trip_reg, err_reg;
    logic [31:0] delay_reg;

    // Fraction of the delay consumed per tick; a changing value re-weights each tick
    assign inc      = (delay_reg == 0) ? Q_MAX : 32'(TICK_NUM / {32'd0, delay_reg}); // R3
    assign tick     = tick_cnt_reg == 32'(TICK_CYCLES - 1);
    assign run      = pickup && !err_reg;
    assign acc_sum  = {1'b0, acc_reg} + {1'b0, inc};
    // Counts the current tick too, so release ends after exactly RLS ticks
    assign rel_done = rel_reg + 32'd1 >= rls_reg; // R16
    assign acc_next = !tick ? acc_reg
                    : run ? (acc_sum[32] ? '1 : acc_sum[31:0]) // R3
                    : rel_done ? '0 : acc_reg; // R16
    assign rel_next = !tick ? rel_reg
                    : run ? '0
                    : rel_done ? rel_reg : rel_reg + 32'd1; // R16

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_reg <= '0;
            acc_reg      <= '0;
            rel_reg      <= '0;
            trip_reg     <= 1'b0;
            err_reg      <= 1'b0;
            delay_reg    <= Q_MAX;
        end else begin
            tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 32'd1;
            acc_reg      <= acc_next;
            rel_reg      <= rel_next;
            trip_reg     <= acc_next >= Q_ONE;
            err_reg      <= err_next;
            delay_reg    <= t_next;
        end
    end

    assign trip    = trip_reg;
    assign set_err = err_reg;
    assign delay_s = delay_reg;

    always_comb begin
        rd_mux = '0;
        unique case (haddr[7:0])
            OFS_CTRL:  rd_mux = {26'd0, ctrl_reg};
            OFS_STAT:  rd_mux = {29'd0, pickup, err_reg, trip_reg};
            OFS_MULT:  rd_mux = k_reg;
            OFS_START: rd_mux = start_reg;
            OFS_MINDT: rd_mux = mindt_reg;
            OFS_RLS:   rd_mux = rls_reg;
            OFS_DELAY: rd_mux = delay_reg;
            OFS_ACC:   rd_mux = acc_reg;
            default: begin
                if (haddr[7:0] >= OFS_PAR && haddr[7:0] < OFS_PAR_END) begin
                    rd_mux = par_reg[rd_par_off[4:2]];
                end else if (haddr[7:0] >= OFS_TBL && haddr[7:0] < OFS_TBL_END) begin
                    rd_mux = rd_tbl_off[2] ? stg_pt[rd_tbl_off[6:3]].dly
                                           : stg_pt[rd_tbl_off[6:3]].cur;
                end
            end
        endcase
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_floor;
        pickup && !err_next |=> $signed(delay_reg) >= $past(mindt_reg);
    endproperty
    a_floor: assert property (p_floor) else $error("delay below floor"); // R7

    property p_twenty;
        r_q >= Q_TWENTY |=> delay_reg == $past(mindt_reg);
    endproperty
    a_twenty: assert property (p_twenty) else $error("no definite delay at 20x"); // R7

    property p_rec_err;
        mode == M_RECIP && pickup && rec_den <= 0 |=> err_reg;
    endproperty
    a_rec_err: assert property (p_rec_err) else $error("reciprocal error missed"); // R1

    property p_par_err;
        mode == M_IEEE2 && pickup && x1 <= 0 |=> err_reg ##1 (acc_reg <= $past(acc_reg));
    endproperty
    a_par_err: assert property (p_par_err) else $error("parameter error missed"); // R6

    property p_tbl_err;
        mode == M_TABLE && !used[1] |=> err_reg && set_err;
    endproperty
    a_tbl_err: assert property (p_tbl_err) else $error("table error missed"); // R11

    property p_staged;
        !restart |=> act_pt == $past(act_pt);
    endproperty
    a_staged: assert property (p_staged) else $error("table changed without restart"); // R12

    property p_trip_hold;
        trip_reg && pickup && !err_reg |=> trip_reg;
    endproperty
    a_trip_hold: assert property (p_trip_hold) else $error("trip dropped in fault"); // R3

    property p_release;
        tick && !run && rel_done |=> acc_reg == 0 ##1 !trip_reg;
    endproperty
    a_release: assert property (p_release) else $error("release did not clear"); // R16

    property p_interp;
        mode == M_TABLE && |seg && lo.dly >= hi.dly && !err_next && t_raw >= mindt_reg
        && r_q < Q_TWENTY
        |=> $signed(delay_reg) <= $past(lo.dly) && $signed(delay_reg) >= $past(hi.dly);
    endproperty
    a_interp: assert property (p_interp) else $error("interpolation out of range"); // R13

    c_trip:    cover property (pickup ##1 trip_reg);
    c_err:     cover property (mode == M_IEEE2 ##1 err_reg);
    c_restart: cover property (restart ##1 mode == M_TABLE && used[2]);
endmodule
`default_nettype wire

// ---- logic/ddc_pkg.sv ----
// Package: constants and types of the dependent delay curve evaluator
`default_nettype none
package ddc_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam int         AW           = 8;
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STAT     = 8'h04;
    localparam logic [7:0] OFS_MULT     = 8'h08;
    localparam logic [7:0] OFS_START    = 8'h0C;
    localparam logic [7:0] OFS_MINDT    = 8'h10;
    localparam logic [7:0] OFS_RLS      = 8'h14;
    localparam logic [7:0] OFS_DELAY    = 8'h18;
    localparam logic [7:0] OFS_ACC      = 8'h1C;
    localparam logic [7:0] OFS_PAR      = 8'h20;
    localparam logic [7:0] OFS_PAR_END  = 8'h34;
    localparam logic [7:0] OFS_TBL      = 8'h40;
    localparam logic [7:0] OFS_TBL_END  = 8'hC0;
    localparam int         NPAR         = 5;
    localparam int         NPT          = 16;
    localparam int         CTRL_RST_BIT = 8;
    localparam int         ST_TRIP      = 0;
    localparam int         ST_ERR       = 1;
    localparam int         ST_PICK      = 2;
    // ************************************************************
    // Fixed point, Q16.16
    // ************************************************************
    localparam int                 FRAC     = 16;
    localparam logic signed [31:0] Q_ONE    = 32'sh0001_0000;
    localparam logic signed [31:0] Q_TWENTY = 32'sh0014_0000;
    localparam logic signed [31:0] Q_MAX    = 32'sh7FFF_FFFF;
    localparam logic signed [31:0] REC_A    = 32'sh0000_56C9;
    localparam logic signed [31:0] REC_B    = 32'sh0000_3C6B;
    localparam logic signed [31:0] LG_A     = 32'sh0005_CCCD;
    localparam logic signed [31:0] LG_B     = 32'sh0001_599A;
    localparam logic signed [31:0] LN2      = 32'sh0000_B172;
    localparam logic [31:0]        MULT_RST  = 32'h0001_0000;
    localparam logic [31:0]        START_RST = 32'h0001_0000;
    localparam logic [31:0]        MINDT_RST = 32'h0000_0CCD;
    localparam logic [31:0]        RLS_RST   = 32'h0000_0032;
    localparam logic [31:0]        PA_RST    = 32'h0000_23D7;
    localparam logic [31:0]        PB_RST    = 32'h0000_051F;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int          CLK_HZ       = 20_000_000;
    localparam int          TICK_US      = 1000;
    localparam int          TICK_CYC_DEF = CLK_HZ / 1_000_000 * TICK_US;
    localparam logic [63:0] TICK_NUM     = (64'd1 << 32) * TICK_US / 1_000_000;
    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [5:0] {
        M_IEC   = 6'b000001,
        M_IEEE  = 6'b000010,
        M_IEEE2 = 6'b000100,
        M_RECIP = 6'b001000,
        M_LOG   = 6'b010000,
        M_TABLE = 6'b100000
    } ddc_mode_type;
    typedef struct packed {
        logic signed [31:0] cur;
        logic signed [31:0] dly;
    } ddc_point_type;
    typedef struct packed {
        logic       vld;
        logic       wr;
        logic [7:0] addr;
    } ddc_aph_type;
    localparam ddc_point_type PT_UNUSED = '{cur: Q_ONE, dly: 32'sh0000_0000};
endpackage
`default_nettype wire

// ---- sim/ddc_tb.sv ----
// Self-checking testbench of the dependent delay curve evaluator
`default_nettype none
module testbench
    import ddc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // Bench state and design
    // ************************************************************
    localparam int      TCK = 4;
    logic               hclk, hresetn, hsel, hwrite;
    logic [31:0]        haddr, hwdata, rd;
    logic [1:0]         htrans;
    logic [2:0]         hsize;
    logic signed [31:0] meas_value;
    wire logic          hreadyout, hresp, trip, set_err;
    wire logic [31:0]   hrdata, delay_s;
    int                 miscompares, n_tests, n;
    real                tc [6];
    real                td [6];
    ddc_curve_eval #(.TICK_CYCLES(TCK)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .meas_value(meas_value), .trip(trip), .set_err(set_err), .delay_s(delay_s));
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] q(input real x);
        return 32'($rtoi(x * 65536.0));
    endfunction
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Entered just after a rising edge; address phase then data phase
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsel <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic w(input logic [7:0] a, input real x);
        ahb(1'b1, a, q(x));
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_r(input string nm, input real e, input real g, input real tol);
        n_tests++;
        if ($isunknown(delay_s) || g < e * (1.0 - tol) || g > e * (1.0 + tol)) begin
            miscompares++;
            $display("[ERR] %s expected %f seen %f", nm, e, g);
        end
    endtask
    // Mode write, settle, then compare the operate delay
    task automatic ev(input logic [31:0] m, input real e, input real tol, input logic er);
        ahb(1'b1, OFS_CTRL, m);
        repeat (3) @(posedge hclk);
        chk("set_err", {31'h0, er}, {31'h0, set_err});
        if (er == 1'b0) chk_r("delay_s", e, $itor($signed(delay_s)) / 65536.0, tol);
    endtask
    task automatic setp(input real a, input real b, input real c, input real d, input real e);
        w(OFS_PAR, a);
        w(8'h24, b);
        w(8'h28, c);
        w(8'h2C, d);
        w(8'h30, e);
    endtask
    // Cycles until trip reaches v, sampled mid-cycle, bounded
    task automatic wait_trip(input logic v);
        n = 0;
        while (trip !== v && n < 3000) begin
            @(negedge hclk);
            n++;
        end
        @(posedge hclk);
    endtask
    initial begin
        repeat (60000) @(posedge hclk);
        miscompares++;
        finish_test;
    end
    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = '0;
        hwdata = '0;
        htrans = 2'b00;
        hsize = 3'b010;
        meas_value = '0;
        miscompares = 0;
        n_tests = 0;
        hresetn = 1'b0;
        tc = '{1.0, 2.0, 5.0, 10.0, 20.0, 40.0};
        td = '{10.0, 6.5, 4.0, 3.0, 2.0, 1.0};
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, OFS_MINDT, '0);
        chk("mindt reset", MINDT_RST, rd);
        ahb(1'b0, OFS_TBL, '0);
        chk("point reset", Q_ONE, rd);
        ahb(1'b1, OFS_ACC, 32'h1234_0000);
        ahb(1'b0, OFS_ACC, '0);
        chk("acc read only", 32'h0000_0000, rd);
        ahb(1'b0, 8'h38, '0);
        chk("unmapped", 32'h0000_0000, rd);
        w(OFS_MULT, 0.5);
        w(OFS_START, 2.0);
        ahb(1'b0, OFS_MULT, '0);
        chk("mult", q(0.5), rd);
        meas_value <= q(4.0);
        ev(32'h08, 0.5 / (0.339 - 0.236 / 2.0), 0.03, 1'b0);
        ev(32'h10, 5.8 - 1.35 * $ln(4.0 / 1.0), 0.04, 1'b0);
        meas_value <= q(40.0);
        ev(32'h08, 0.05, 0.001, 1'b0);
        meas_value <= q(4.0);
        setp(80.0, 2.0, 0.0, 0.0, 0.0);
        ev(32'h01, 40.0 / 3.0, 0.04, 1'b0);
        // Trip by integration, then a fixed release time in two curves
        meas_value <= 0;
        w(OFS_RLS, 10.0 / 65536.0);
        // Let the fraction left over from the earlier cases release first
        repeat (16 * TCK) @(posedge hclk);
        foreach (tc[i]) if (i < 2) begin
            ahb(1'b1, OFS_CTRL, (i == 0) ? 32'h08 : 32'h01);
            meas_value <= q((i == 0) ? 40.0 : 38.0);
            wait_trip(1'b1);
            chk_r("trip cycles", ((i == 0) ? 50.0 : 40000.0 / 360.0) * TCK, n, 0.12);
            meas_value <= 0;
            wait_trip(1'b0);
            chk_r("release cycles", 10.0 * TCK, n, 0.2);
        end
        meas_value <= q(4.0);
        setp(19.61, 0.491, 2.0, 0.0, 0.0);
        ev(32'h02, 0.5 * (19.61 / 3.0 + 0.491), 0.04, 1'b0);
        setp(0.2078, 0.863, 0.8, -0.418, 0.1947);
        ev(32'h04, 0.5 * (0.2078 + 0.863 / 1.2 - 0.418 / 1.44 + 0.1947 / 1.728), 0.05,
           1'b0);
        w(8'h28, 2.5);
        ev(32'h04, 0.0, 0.0, 1'b1);
        setp(80.0, 0.0, 0.0, 0.0, 0.0);
        ev(32'h01, 0.0, 0.0, 1'b1);
        ev(32'h20, 0.0, 0.0, 1'b1);
        foreach (tc[i]) begin
            w(OFS_TBL + 8'(8 * i), tc[i]);
            w(OFS_TBL + 8'(8 * i + 4), td[i]);
        end
        for (int i = 6; i < NPT; i++) begin
            w(OFS_TBL + 8'(8 * i), 1.0);
            w(OFS_TBL + 8'(8 * i + 4), 0.0);
        end
        ev(32'h20, 0.0, 0.0, 1'b1);
        meas_value <= q(7.0);
        ev(32'h120, 6.5 - 2.5 * 1.5 / 3.0, 0.01, 1'b0);
        meas_value <= q(3.0);
        ev(32'h20, 10.0 - 3.5 * 0.5, 0.01, 1'b0);
        w(OFS_TBL + 8'h10, 1.5);
        ev(32'h120, 0.0, 0.0, 1'b1);
        finish_test;
    end
endmodule
`default_nettype wire
